// [rtl/bmpc_pkg.sv]
// shared constants and state types of the boost mode and phase configuration block
package bmpc_pkg;

    // *****************************************
    // serial frame layout
    // *****************************************
    localparam logic [4:0] BMPC_FRAME_BITS = 5'h10;  // one frame is 16 bits
    localparam logic [4:0] BMPC_CMD_BITS = 5'h08;    // command byte: write flag and address

    // *****************************************
    // register offsets
    // *****************************************
    localparam logic [6:0] BMPC_ADDR_CONTROL = 7'h00;
    localparam logic [6:0] BMPC_ADDR_GATE_DRIVER_OUTPUT_MAP = 7'h02;
    localparam logic [6:0] BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES = 7'h0b;
    localparam logic [6:0] BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES = 7'h0c;
    localparam logic [6:0] BMPC_ADDR_GATE_DRIVER_PHASE_MAP = 7'h0f;
    localparam logic [6:0] BMPC_ADDR_PHASE_ROUTE_SELECT = 7'h10;
    localparam logic [6:0] BMPC_ADDR_STATUS = 7'h1f;

    // *****************************************
    // field positions and reset values
    // *****************************************
    localparam int BMPC_CTRL_CFG_DONE_BIT = 0;
    localparam int BMPC_CTRL_OUT1_EN_BIT = 1;
    localparam int BMPC_STAT_GATE_OK_BIT = 0;
    localparam int BMPC_STAT_OVER_TEMP_BIT = 1;
    localparam int BMPC_STAT_GATE_ERR_BIT = 2;
    localparam int BMPC_STAT_UNDER_V_BIT = 3;
    localparam int BMPC_STAT_OVER_V_BIT = 4;
    localparam int BMPC_STAT_MODE_LSB = 5;
    localparam logic [3:0] BMPC_PHASE_EN_RESET = 4'h0;
    localparam logic [1:0] BMPC_ROUTE_RESET = 2'h0;
    localparam logic BMPC_MAP_RESET = 1'b0;

    // *****************************************
    // synchronised pin positions
    // *****************************************
    localparam int BMPC_PIN_EN = 0;
    localparam int BMPC_PIN_PON = 1;
    localparam int BMPC_PIN_OVT = 2;
    localparam int BMPC_PIN_GERR = 3;
    localparam int BMPC_PIN_UV = 4;
    localparam int BMPC_PIN_OV = 5;
    localparam int BMPC_PIN_GOK = 6;
    localparam int BMPC_PIN_W = 7;

    // *****************************************
    // types
    // *****************************************
    typedef enum logic [1:0] {
        BMPC_MODE_OFF,
        BMPC_MODE_CONFIG,
        BMPC_MODE_OPERATION,
        BMPC_MODE_FAIL_SILENT
    } bmpc_mode_t;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sclk_prev;
        logic active;
        logic [4:0] bit_cnt;
        logic [7:0] shift_in;
        logic [7:0] rd_shift;
        logic is_write;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wr_stb;
        logic sdo;
    } bmpc_spi_state_t;

    typedef struct packed {
        logic [BMPC_PIN_W-1:0] sync1;
        logic [BMPC_PIN_W-1:0] sync2;
        bmpc_mode_t mode;
        logic cfg_done;
        logic out1_en;
        logic gd_output_map;
        logic gd_phase_map;
        logic [3:0] out_a_en;
        logic [3:0] out_b_en;
        logic [1:0] route;
        logic gate_en;
        logic out_on;
        logic batmon;
        logic routed_on;
    } bmpc_top_state_t;

endpackage

// [rtl/bmpc_spi_slave.sv]
// serial register port: oversampled slave, 16-bit frames, mode 0
`timescale 1ns/10ps
`default_nettype none

module bmpc_spi_slave
    import bmpc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // pins
    input wire logic sclk_in,
    input wire logic csb_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // register side
    input wire logic enable_in,
    input wire logic [7:0] rdata_in,
    output logic [6:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_stb_out
);

    bmpc_spi_state_t q;
    bmpc_spi_state_t d;
    logic csb_s;
    logic sclk_s;
    logic sdi_s;

    // only the second synchroniser stage is looked at
    assign csb_s = q.sync2[2];
    assign sclk_s = q.sync2[1];
    assign sdi_s = q.sync2[0];

    // *****************************************
    // frame engine
    // *****************************************
    always_comb begin
        d = q;
        d.wr_stb = 1'b0;
        d.sync1 = {csb_n_in, sclk_in, sdi_in};
        d.sync2 = q.sync1;
        d.sclk_prev = sclk_s;
        if (!enable_in || csb_s) begin
            // deselect or disabled: frame aborted, nothing is written
            d.active = 1'b0;
            d.bit_cnt = 5'h00;
            d.sdo = 1'b0;
        end else begin
            d.active = 1'b1;
            if (sclk_s && !q.sclk_prev && q.bit_cnt < BMPC_FRAME_BITS) begin
                d.shift_in = {q.shift_in[6:0], sdi_s};
                d.bit_cnt = q.bit_cnt + 5'h01;
                if (q.bit_cnt == BMPC_CMD_BITS - 5'h01) begin
                    d.is_write = q.shift_in[6];
                    d.addr = {q.shift_in[5:0], sdi_s};
                end
                if (q.bit_cnt == BMPC_FRAME_BITS - 5'h01) begin
                    d.wdata = {q.shift_in[6:0], sdi_s};
                    d.wr_stb = q.is_write;
                end
            end
            if (!sclk_s && q.sclk_prev) begin
                // read data goes out on falling edges; address has settled for 3 cycles
                if (q.bit_cnt == BMPC_CMD_BITS) begin
                    d.sdo = rdata_in[7];
                    d.rd_shift = {rdata_in[6:0], 1'b0};
                end else if (q.bit_cnt > BMPC_CMD_BITS && q.bit_cnt < BMPC_FRAME_BITS) begin
                    d.sdo = q.rd_shift[7];
                    d.rd_shift = {q.rd_shift[6:0], 1'b0};
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q <= '0;
            q.sync1 <= 3'h7;
            q.sync2 <= 3'h7;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign sdo_out = q.sdo;
    assign sdo_oe_out = q.active;
    assign addr_out = q.addr;
    assign wdata_out = q.wdata;
    assign wr_stb_out = q.wr_stb;

endmodule

`default_nettype wire

// [rtl/bmpc_top.sv]
// mode sequencer and phase mapping registers of the boost converter controller
//
// Summary of operation
// - leave off for configuration when supply above power-on threshold and enable high
// - configuration mode accepts serial writes to configuration registers
// - writing configuration-complete bit to one enters operation mode
// - configuration-complete set locks all configuration registers
// - in operation, output-one enable starts the gate driver supply regulator
// - output voltage switches on only after gate supply reports regulation
// - battery monitoring available only while the converter runs
// - operation goes fail-silent on over-temperature or gate supply error
// - operation goes fail-silent on supply under-voltage or over-voltage
// - fail-silent turns the output off, only serial port stays working
// - up to four internal phases over at most two virtual outputs
// - output one phase enables on bits 3..0 for phases four..one
// - output two phase enables likewise, upper four bits reserved
// - gate driver output map bit 0 zero means output one; host never writes one
// - gate driver phase map bit 0 zero means output one; host never writes one
// - two-bit route code picks virtual phase one to four for physical phase
// - off mode whenever supply below power-on threshold or enable low
// - clearing configuration-complete restores configuration write access
`timescale 1ns/10ps
`default_nettype none

module bmpc_top
    import bmpc_pkg::*;
(
    // clock, reset, clock enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // device pins
    input wire logic en_pin_in,
    input wire logic sclk_in,
    input wire logic csb_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // analog monitors, asynchronous levels
    input wire logic supply_above_pon_in,
    input wire logic over_temp_in,
    input wire logic gate_supply_error_in,
    input wire logic supply_under_voltage_in,
    input wire logic supply_over_voltage_in,
    input wire logic gate_supply_regulated_in,
    // mode and power control
    output bmpc_mode_t mode_out,
    output logic config_locked_out,
    output logic gate_supply_enable_out,
    output logic first_output_voltage_on_out,
    output logic battery_monitor_enable_out,
    // phase configuration
    output logic [3:0] out_a_phase_enables_out,
    output logic [3:0] out_b_phase_enables_out,
    output logic physical_phase_output_map_out,
    output logic physical_phase_virtual_map_out,
    output logic [1:0] phase_route_code_out,
    output logic routed_phase_active_out
);

    // *****************************************
    // declarations
    // *****************************************
    bmpc_top_state_t q;
    bmpc_top_state_t d;
    logic [6:0] spi_addr;
    logic [7:0] spi_wdata;
    logic spi_wr;
    logic [7:0] spi_rdata;
    logic spi_enable;
    logic [BMPC_PIN_W-1:0] pins_raw;

    // gather the asynchronous levels for the common synchroniser
    always_comb begin
        pins_raw = '0;
        pins_raw[BMPC_PIN_EN] = en_pin_in;
        pins_raw[BMPC_PIN_PON] = supply_above_pon_in;
        pins_raw[BMPC_PIN_OVT] = over_temp_in;
        pins_raw[BMPC_PIN_GERR] = gate_supply_error_in;
        pins_raw[BMPC_PIN_UV] = supply_under_voltage_in;
        pins_raw[BMPC_PIN_OV] = supply_over_voltage_in;
        pins_raw[BMPC_PIN_GOK] = gate_supply_regulated_in;
    end

    // *****************************************
    // helper functions
    // *****************************************

    // true for the addresses that the configuration lock guards
    function automatic logic is_config_addr(input logic [6:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            BMPC_ADDR_GATE_DRIVER_OUTPUT_MAP: hit = 1'b1;
            BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES: hit = 1'b1;
            BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES: hit = 1'b1;
            BMPC_ADDR_GATE_DRIVER_PHASE_MAP: hit = 1'b1;
            BMPC_ADDR_PHASE_ROUTE_SELECT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // read mux; reserved bits and unmapped addresses read as zero
    function automatic logic [7:0] read_reg(input logic [6:0] addr, input bmpc_top_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            BMPC_ADDR_CONTROL: begin
                v[BMPC_CTRL_CFG_DONE_BIT] = s.cfg_done;
                v[BMPC_CTRL_OUT1_EN_BIT] = s.out1_en;
            end
            BMPC_ADDR_GATE_DRIVER_OUTPUT_MAP: v[0] = s.gd_output_map;
            BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES: v[3:0] = s.out_a_en;
            BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES: v[3:0] = s.out_b_en;
            BMPC_ADDR_GATE_DRIVER_PHASE_MAP: v[0] = s.gd_phase_map;
            BMPC_ADDR_PHASE_ROUTE_SELECT: v[1:0] = s.route;
            BMPC_ADDR_STATUS: begin
                v[BMPC_STAT_GATE_OK_BIT] = s.sync2[BMPC_PIN_GOK];
                v[BMPC_STAT_OVER_TEMP_BIT] = s.sync2[BMPC_PIN_OVT];
                v[BMPC_STAT_GATE_ERR_BIT] = s.sync2[BMPC_PIN_GERR];
                v[BMPC_STAT_UNDER_V_BIT] = s.sync2[BMPC_PIN_UV];
                v[BMPC_STAT_OVER_V_BIT] = s.sync2[BMPC_PIN_OV];
                v[BMPC_STAT_MODE_LSB +: 2] = 2'(s.mode);
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // *****************************************
    // serial register port
    // *****************************************

    // the port is dead in off mode, alive in every other mode
    assign spi_enable = (q.mode != BMPC_MODE_OFF);
    assign spi_rdata = read_reg(spi_addr, q);

    bmpc_spi_slave u_spi (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .sclk_in(sclk_in),
        .csb_n_in(csb_n_in),
        .sdi_in(sdi_in),
        .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out),
        .enable_in(spi_enable),
        .rdata_in(spi_rdata),
        .addr_out(spi_addr),
        .wdata_out(spi_wdata),
        .wr_stb_out(spi_wr)
    );

    // *****************************************
    // next state
    // *****************************************
    always_comb begin
        logic supply_ok;
        logic enable_pin;
        logic fault;
        logic gate_ok;
        supply_ok = 1'b0;
        enable_pin = 1'b0;
        fault = 1'b0;
        gate_ok = 1'b0;
        d = q;

        // two-stage synchroniser, only stage two feeds logic
        d.sync1 = pins_raw;
        d.sync2 = q.sync1;
        supply_ok = q.sync2[BMPC_PIN_PON];
        enable_pin = q.sync2[BMPC_PIN_EN];
        gate_ok = q.sync2[BMPC_PIN_GOK];
        fault = q.sync2[BMPC_PIN_OVT] | q.sync2[BMPC_PIN_GERR]
            | q.sync2[BMPC_PIN_UV] | q.sync2[BMPC_PIN_OV];

        // register writes; only possible outside off because the port is disabled there
        if (spi_wr && spi_enable) begin
            if (spi_addr == BMPC_ADDR_CONTROL) begin
                d.cfg_done = spi_wdata[BMPC_CTRL_CFG_DONE_BIT];
                d.out1_en = spi_wdata[BMPC_CTRL_OUT1_EN_BIT];
            end else if (is_config_addr(spi_addr) && !q.cfg_done) begin
                case (spi_addr)
                    // the map bits store what is written; a one is the host's fault
                    BMPC_ADDR_GATE_DRIVER_OUTPUT_MAP: d.gd_output_map = spi_wdata[0];
                    BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES: d.out_a_en = spi_wdata[3:0];
                    BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES: d.out_b_en = spi_wdata[3:0];
                    BMPC_ADDR_GATE_DRIVER_PHASE_MAP: d.gd_phase_map = spi_wdata[0];
                    BMPC_ADDR_PHASE_ROUTE_SELECT: d.route = spi_wdata[1:0];
                    default: d.route = q.route;
                endcase
            end
        end

        // mode sequencer; losing supply or enable beats every other move
        if (!supply_ok || !enable_pin) begin
            d.mode = BMPC_MODE_OFF;
        end else begin
            case (q.mode)
                BMPC_MODE_OFF: d.mode = BMPC_MODE_CONFIG;
                BMPC_MODE_CONFIG: begin
                    if (q.cfg_done) begin
                        d.mode = BMPC_MODE_OPERATION;
                    end
                end
                BMPC_MODE_OPERATION: begin
                    if (fault) begin
                        d.mode = BMPC_MODE_FAIL_SILENT;
                    end else if (!q.cfg_done) begin
                        d.mode = BMPC_MODE_CONFIG;
                    end
                end
                // fail-silent is left only through off, by the enable pin or by losing supply
                BMPC_MODE_FAIL_SILENT: d.mode = BMPC_MODE_FAIL_SILENT;
                default: d.mode = BMPC_MODE_OFF;
            endcase
        end

        // off clears everything so a restart begins from a clean configuration
        if (d.mode == BMPC_MODE_OFF) begin
            d.cfg_done = 1'b0;
            d.out1_en = 1'b0;
            d.gd_output_map = BMPC_MAP_RESET;
            d.gd_phase_map = BMPC_MAP_RESET;
            d.out_a_en = BMPC_PHASE_EN_RESET;
            d.out_b_en = BMPC_PHASE_EN_RESET;
            d.route = BMPC_ROUTE_RESET;
        end

        // power path, registered so that it tracks the mode of the same cycle
        d.gate_en = (d.mode == BMPC_MODE_OPERATION) && d.out1_en;
        d.out_on = d.gate_en && gate_ok;
        d.batmon = d.out_on;
        // physical phase runs when its selected virtual phase of output one is on
        d.routed_on = d.out_on && d.out_a_en[d.route];
    end

    // *****************************************
    // state register
    // *****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q <= '0;
            q.mode <= BMPC_MODE_OFF;
        end else if (ce_in) begin
            q <= d;
        end
    end

    // *****************************************
    // outputs
    // *****************************************
    assign mode_out = q.mode;
    assign config_locked_out = q.cfg_done;
    assign gate_supply_enable_out = q.gate_en;
    assign first_output_voltage_on_out = q.out_on;
    assign battery_monitor_enable_out = q.batmon;
    assign out_a_phase_enables_out = q.out_a_en;
    assign out_b_phase_enables_out = q.out_b_en;
    assign physical_phase_output_map_out = q.gd_output_map;
    assign physical_phase_virtual_map_out = q.gd_phase_map;
    assign phase_route_code_out = q.route;
    assign routed_phase_active_out = q.routed_on;

endmodule

`default_nettype wire

// [verification/bmpc_checker.sv]
// concurrent checks on the ports of the mode and phase block
`timescale 1ns/10ps
`default_nettype none

module bmpc_checker
    import bmpc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // monitor pins
    input wire logic over_temp_in,
    input wire logic gate_supply_error_in,
    input wire logic supply_under_voltage_in,
    input wire logic supply_over_voltage_in,
    input wire logic gate_supply_regulated_in,
    // outputs under watch
    input wire logic sdo_oe_out,
    input wire bmpc_mode_t mode_out,
    input wire logic config_locked_out,
    input wire logic gate_supply_enable_out,
    input wire logic first_output_voltage_on_out,
    input wire logic battery_monitor_enable_out,
    input wire logic [3:0] out_a_phase_enables_out,
    input wire logic [1:0] phase_route_code_out,
    input wire logic routed_phase_active_out
);
    // *****************************************
    // properties
    // *****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // three samples allow for the serial port lagging the mode by a cycle
    a_off_quiet: assert property (
        (mode_out == BMPC_MODE_OFF) [*3] |->
        !sdo_oe_out && !config_locked_out && out_a_phase_enables_out == 4'h0)
        else $error("off mode not quiet");
    a_power_op_only: assert property (
        mode_out != BMPC_MODE_OPERATION |->
        !gate_supply_enable_out && !first_output_voltage_on_out)
        else $error("power on outside operation");
    a_out_needs_reg: assert property (
        $rose(first_output_voltage_on_out) |->
        gate_supply_enable_out && $past(gate_supply_regulated_in, 2))
        else $error("output on before gate regulation");
    a_batmon_running: assert property (
        battery_monitor_enable_out |-> first_output_voltage_on_out)
        else $error("battery monitor while converter off");
    a_temp_gate_fault: assert property (
        mode_out == BMPC_MODE_OPERATION && (over_temp_in || gate_supply_error_in) |->
        ##[1:4] mode_out == BMPC_MODE_FAIL_SILENT)
        else $error("no fail-silent after temp or gate fault");
    a_supply_fault: assert property (
        mode_out == BMPC_MODE_OPERATION && (supply_under_voltage_in || supply_over_voltage_in)
        |-> ##[1:4] mode_out == BMPC_MODE_FAIL_SILENT)
        else $error("no fail-silent after supply fault");
    a_cfg_to_op: assert property (
        $rose(config_locked_out) |-> ##[0:1] mode_out == BMPC_MODE_OPERATION)
        else $error("no operation after configuration done");
    a_lock_holds: assert property (
        config_locked_out [*2] |->
        $stable(out_a_phase_enables_out) && $stable(phase_route_code_out))
        else $error("locked register changed");
    a_route_active: assert property (
        routed_phase_active_out ==
        (first_output_voltage_on_out && out_a_phase_enables_out[phase_route_code_out]))
        else $error("routed phase does not follow route code");

    // main scenarios reached
    c_fail_silent: cover property (mode_out == BMPC_MODE_FAIL_SILENT);
    c_routed: cover property (routed_phase_active_out);
    c_unlock: cover property ($fell(config_locked_out) && mode_out != BMPC_MODE_OFF);
endmodule

bind bmpc_top bmpc_checker bmpc_checker_i (
    .clk_in, .rst_in, .over_temp_in, .gate_supply_error_in, .supply_under_voltage_in,
    .supply_over_voltage_in, .gate_supply_regulated_in, .sdo_oe_out, .mode_out,
    .config_locked_out, .gate_supply_enable_out, .first_output_voltage_on_out,
    .battery_monitor_enable_out, .out_a_phase_enables_out, .phase_route_code_out,
    .routed_phase_active_out
);

`default_nettype wire

// [verification/bmpc_host_model.sv]
// serial master model standing in for the microcontroller
`timescale 1ns/10ps
`default_nettype none

module bmpc_host_model (
    // clock
    input wire logic clk_in,
    // serial pins, deselected with the clock parked low at rest
    output logic sclk_out = 1'b0,
    output logic csb_n_out = 1'b1,
    output logic sdi_out = 1'b0,
    input wire logic sdo_in
);
    // *****************************************
    // frame engine
    // *****************************************
    // one frame msb first, four system clocks per half period;
    // fewer than 16 bits makes an aborted frame
    task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_in);
        csb_n_out <= 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            sdi_out <= frame[i];
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            // taken at the end of the high phase: the device's input sync delays its data
            if (i < 8) rd[i] = sdo_in;
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        csb_n_out <= 1'b1;
        sdi_out <= ~sdi_out;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

`default_nettype wire

// [verification/boost_mode_and_phase_config_tb.sv]
// self-checking bench for the mode sequencer and phase registers
`timescale 1ns/10ps
`default_nettype none

module boost_mode_and_phase_config_tb
    import bmpc_pkg::*;
;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} bmpc_row_t;
    logic clk_in = 1'b0, rst_in = 1'b1, en_pin_in = 1'b0, supply_above_pon_in = 1'b0;
    logic gate_supply_regulated_in = 1'b0, sdo_last = 1'b0;
    logic [3:0] flt = 4'h0;
    logic sclk_in, csb_n_in, sdi_in, sdo_out, sdo_oe_out, sdo_line, config_locked_out;
    logic gate_supply_enable_out, first_output_voltage_on_out, battery_monitor_enable_out;
    logic physical_phase_output_map_out, physical_phase_virtual_map_out, routed_phase_active_out;
    logic [3:0] out_a_phase_enables_out, out_b_phase_enables_out;
    logic [1:0] phase_route_code_out;
    bmpc_mode_t mode_out;
    int bad_count = 0, checked = 0;
    // reserved bits always written as zero, map bits never one
    bmpc_row_t rows [6] = '{
        '{BMPC_ADDR_GATE_DRIVER_OUTPUT_MAP, 8'h00, 8'h00},
        '{BMPC_ADDR_GATE_DRIVER_PHASE_MAP, 8'h00, 8'h00},
        '{BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES, 8'h04, 8'h04},
        '{BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES, 8'h09, 8'h09},
        '{BMPC_ADDR_PHASE_ROUTE_SELECT, 8'h02, 8'h02},
        '{7'h05, 8'h5a, 8'h00}};

    always #50 clk_in = ~clk_in;
    // a released data line shows the inverse of its last driven level
    always @(posedge clk_in) if (sdo_oe_out) sdo_last <= sdo_out;
    assign sdo_line = sdo_oe_out ? sdo_out : ~sdo_last;

    bmpc_top bmpc_top_i (.clk_in, .rst_in, .ce_in(1'b1), .en_pin_in, .sclk_in, .csb_n_in,
        .sdi_in, .sdo_out, .sdo_oe_out, .supply_above_pon_in, .over_temp_in(flt[0]),
        .gate_supply_error_in(flt[1]), .supply_under_voltage_in(flt[2]),
        .supply_over_voltage_in(flt[3]), .gate_supply_regulated_in, .mode_out,
        .config_locked_out, .gate_supply_enable_out, .first_output_voltage_on_out,
        .battery_monitor_enable_out, .out_a_phase_enables_out, .out_b_phase_enables_out,
        .physical_phase_output_map_out, .physical_phase_virtual_map_out,
        .phase_route_code_out, .routed_phase_active_out);
    bmpc_host_model bmpc_host_model_i (.clk_in, .sclk_out(sclk_in), .csb_n_out(csb_n_in),
        .sdi_out(sdi_in), .sdo_in(sdo_line));

    // *****************************************
    // helpers
    // *****************************************
    task automatic close_out;
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        bmpc_host_model_i.xfer({1'b1, a, d}, 16, r);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] r);
        bmpc_host_model_i.xfer({1'b0, a, 8'h00}, 16, r);
    endtask
    // port image of each configuration register
    function automatic logic [7:0] port_of(input logic [6:0] a);
        case (a)
            BMPC_ADDR_GATE_DRIVER_OUTPUT_MAP: port_of = 8'(physical_phase_output_map_out);
            BMPC_ADDR_GATE_DRIVER_PHASE_MAP: port_of = 8'(physical_phase_virtual_map_out);
            BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES: port_of = 8'(out_a_phase_enables_out);
            BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES: port_of = 8'(out_b_phase_enables_out);
            BMPC_ADDR_PHASE_ROUTE_SELECT: port_of = 8'(phase_route_code_out);
            default: port_of = 8'h00;
        endcase
    endfunction
    // mode, lock, gate, output, battery monitor, routed phase
    function automatic logic [7:0] pw();
        return {1'b0, mode_out, config_locked_out, gate_supply_enable_out,
            first_output_voltage_on_out, battery_monitor_enable_out, routed_phase_active_out};
    endfunction
    // bounded wait for a power state; running out ends the run
    task automatic wait_pw(input logic [7:0] e);
        for (int n = 0; n < 60 && pw() !== e; n++) @(negedge clk_in);
        chk(pw(), e, "power state");
        if (pw() !== e) close_out();
    endtask

    // *****************************************
    // main sequence
    // *****************************************
    initial begin
        logic [7:0] r;
        repeat (4) @(posedge clk_in);
        chk(pw(), 8'h00, "reset state");
        rst_in <= 1'b0;
        en_pin_in <= 1'b1;
        supply_above_pon_in <= 1'b1;
        wait_pw(8'h20);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a, r);
            chk(r, rows[k].e, "readback");
            chk(port_of(rows[k].a), rows[k].e, "register port");
        end
        // every route code, ending on code 2
        for (int c = 0; c < 4; c++) begin
            wr(BMPC_ADDR_PHASE_ROUTE_SELECT, 8'(c ^ 1));
            chk({6'h0, phase_route_code_out}, 8'(c ^ 1), "route code");
        end
        wr(BMPC_ADDR_CONTROL, 8'h03);
        wait_pw(8'h58);
        @(posedge clk_in);
        gate_supply_regulated_in <= 1'b1;
        wait_pw(8'h5f);
        wr(BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES, 8'h01);
        rd(BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES, r);
        chk(r, 8'h04, "locked write");
        wait_pw(8'h5f);
        // each fault alone, then restart through off
        for (int f = 0; f < 4; f++) begin
            @(posedge clk_in);
            flt <= 4'(1 << f);
            wait_pw(8'h70);
            rd(BMPC_ADDR_STATUS, r);
            chk(r, {3'b011, 4'(1 << f), 1'b1}, "status");
            @(posedge clk_in);
            flt <= 4'h0;
            en_pin_in <= 1'b0;
            wait_pw(8'h00);
            chk(port_of(BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES), 8'h00, "off clear");
            @(posedge clk_in);
            en_pin_in <= 1'b1;
            wait_pw(8'h20);
            wr(BMPC_ADDR_OUTPUT_ONE_PHASE_ENABLES, 8'h04);
            wr(BMPC_ADDR_PHASE_ROUTE_SELECT, 8'h02);
            wr(BMPC_ADDR_CONTROL, 8'h03);
            wait_pw(8'h5f);
        end
        wr(BMPC_ADDR_CONTROL, 8'h02);
        wait_pw(8'h20);
        wr(BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES, 8'h03);
        rd(BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES, r);
        chk(r, 8'h03, "unlocked write");
        // ten bits then deselect: the write must be dropped
        bmpc_host_model_i.xfer({1'b1, BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES, 8'h0a}, 10, r);
        rd(BMPC_ADDR_OUTPUT_TWO_PHASE_ENABLES, r);
        chk(r, 8'h03, "aborted frame");
        @(posedge clk_in);
        supply_above_pon_in <= 1'b0;
        wait_pw(8'h00);
        close_out();
    end
endmodule

`default_nettype wire
